// ===== pkg/gpm_defines.svh
`ifndef GPM_DEFINES_SVH
`define GPM_DEFINES_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define GPM_ADDR_OUT_DATA      32'h400e0e38
`define GPM_ADDR_IRQ_MASK      32'h400e0e48
`define GPM_ADDR_IRQ_STATUS    32'h400e0e4c
`define GPM_ADDR_GATE_ENABLE   32'h400e0ea0
`define GPM_ADDR_GATE_DISABLE  32'h400e0ea4
`define GPM_ADDR_GATE_STATUS   32'h400e0ea8
`define GPM_ADDR_AIM_ENABLE    32'h400e0eb0
`define GPM_ADDR_AIM_DISABLE   32'h400e0eb4
`define GPM_ADDR_AIM_MASK      32'h400e0eb8
`define GPM_ADDR_EDGE_SEL      32'h400e0ec0
`define GPM_ADDR_LEVEL_SEL     32'h400e0ec4
`define GPM_ADDR_EL_STATUS     32'h400e0ec8
`define GPM_ADDR_FALL_LOW_SEL  32'h400e0ed0
`define GPM_ADDR_RISE_HIGH_SEL 32'h400e0ed4
`define GPM_ADDR_POL_STATUS    32'h400e0ed8
`define GPM_ADDR_PROT_MODE     32'h400e0ee4
`define GPM_ADDR_PROT_STATUS   32'h400e0ee8

// ----------------------------------------------------------------
// field positions and key
// ----------------------------------------------------------------
`define GPM_KEY_VALUE          24'h50494f
`define GPM_KEY_MSB            31
`define GPM_KEY_LSB            8
`define GPM_PROT_EN_BIT        0
`define GPM_VIOL_FLAG_BIT      0
`define GPM_VIOL_SRC_MSB       23
`define GPM_VIOL_SRC_LSB       8
`define GPM_OFFSET_MSB         7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GPM_RST_WORD           32'h0000_0000
`define GPM_RST_BIT            1'b0
`define GPM_RST_SRC            16'h0000

`endif

// ===== pkg/gpm_pkg.sv
package gpm_pkg;

    typedef logic [31:0] gpm_word_t;

    // event chosen by {polarity, edge_level} in extra mode
    typedef enum logic [1:0]
    {
        GPM_EVT_FALL = 2'h0,
        GPM_EVT_LOW  = 2'h1,
        GPM_EVT_RISE = 2'h2,
        GPM_EVT_HIGH = 2'h3
    } gpm_evt_t;

endpackage

// ===== rtl/gpm_port_ctrl.sv
`timescale 1ns/100ps
`include "gpm_defines.svh"

// Overview of operation
// - writing one to gate disable blocks later output data writes to that line
// - gate status reads one where output data writes drive the line
// - extra mode enable makes the line use edge/level and polarity event
// - extra mode disable returns the line to both-edge detection
// - extra mode mask reads zero for both-edge, one for selected event
// - edge select makes the selected event an edge event
// - level select makes the selected event a level event
// - edge/level status reads zero for edge, one for level
// - fall/low select sets polarity to falling edge or low level
// - rise/high select sets polarity to rising edge or high level
// - polarity and edge/level pick fall, low, rise or high event
// - protect enable changes only when the write carries the correct key
// - a protect mode write with a wrong key leaves protect enable alone
// - the key field of protect mode always reads zero
// - violation flag sets on violation, clears on status read
// - violation source holds the offset of the refused write
// - gate enable and disable writes act only while protection is off
module gpm_port_ctrl
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // register port
    input  wire logic [31:0]       addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output gpm_pkg::gpm_word_t     rdata,
    // i/o lines
    input  wire logic [31:0]       line_in,
    output gpm_pkg::gpm_word_t     line_out,
    // interrupt
    output logic                   irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    gpm_pkg::gpm_word_t output_data_r;
    gpm_pkg::gpm_word_t gate_r;
    gpm_pkg::gpm_word_t aim_r;
    gpm_pkg::gpm_word_t el_r;
    gpm_pkg::gpm_word_t pol_r;
    gpm_pkg::gpm_word_t mask_r;
    gpm_pkg::gpm_word_t stat_r;
    gpm_pkg::gpm_word_t stat_nxt;
    gpm_pkg::gpm_word_t line_prev_r;
    gpm_pkg::gpm_word_t line_evt;
    gpm_pkg::gpm_word_t rdata_r;
    gpm_pkg::gpm_word_t rdata_nxt;
    logic               prot_en_r;
    logic               viol_flag_r;
    logic [15:0]        viol_src_r;
    logic               irq_r;
    logic               key_ok;
    logic               violation;
    logic               gate_wr;

    assign rdata    = rdata_r;
    assign line_out = output_data_r;
    assign irq      = irq_r;

    // ----------------------------------------------------------------
    // write protection
    // ----------------------------------------------------------------
    assign key_ok  = (wdata[`GPM_KEY_MSB:`GPM_KEY_LSB] == `GPM_KEY_VALUE);
    assign gate_wr = wr && ((addr == `GPM_ADDR_GATE_ENABLE)
                         || (addr == `GPM_ADDR_GATE_DISABLE));
    assign violation = gate_wr && prot_en_r;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            prot_en_r <= `GPM_RST_BIT;
        else if (wr && (addr == `GPM_ADDR_PROT_MODE) && key_ok)
            prot_en_r <= wdata[`GPM_PROT_EN_BIT];
    end

    // a violation in the read cycle cannot happen (strobes exclusive),
    // but set is still given priority over the clear
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            viol_flag_r <= `GPM_RST_BIT;
            viol_src_r  <= `GPM_RST_SRC;
        end
        else if (violation)
        begin
            viol_flag_r <= 1'b1;
            viol_src_r  <= {8'h00, addr[`GPM_OFFSET_MSB:0]};
        end
        else if (rd && (addr == `GPM_ADDR_PROT_STATUS))
            viol_flag_r <= 1'b0;
    end

    // ----------------------------------------------------------------
    // output write gate and output data
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            gate_r <= `GPM_RST_WORD;
        else if (gate_wr && !prot_en_r)
        begin
            if (addr == `GPM_ADDR_GATE_ENABLE)
                gate_r <= gate_r | wdata;
            else
                gate_r <= gate_r & ~wdata;
        end
    end

    // lines whose gate is closed keep their value
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            output_data_r <= `GPM_RST_WORD;
        else if (wr && (addr == `GPM_ADDR_OUT_DATA))
            output_data_r <= (output_data_r & ~gate_r) | (wdata & gate_r);
    end

    // ----------------------------------------------------------------
    // interrupt mode selection
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            aim_r <= `GPM_RST_WORD;
        else if (wr && (addr == `GPM_ADDR_AIM_ENABLE))
            aim_r <= aim_r | wdata;
        else if (wr && (addr == `GPM_ADDR_AIM_DISABLE))
            aim_r <= aim_r & ~wdata;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            el_r <= `GPM_RST_WORD;
        else if (wr && (addr == `GPM_ADDR_EDGE_SEL))
            el_r <= el_r & ~wdata;
        else if (wr && (addr == `GPM_ADDR_LEVEL_SEL))
            el_r <= el_r | wdata;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            pol_r <= `GPM_RST_WORD;
        else if (wr && (addr == `GPM_ADDR_FALL_LOW_SEL))
            pol_r <= pol_r & ~wdata;
        else if (wr && (addr == `GPM_ADDR_RISE_HIGH_SEL))
            pol_r <= pol_r | wdata;
    end

    // ----------------------------------------------------------------
    // per-line event detection
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            line_prev_r <= `GPM_RST_WORD;
        else
            line_prev_r <= line_in;
    end

    // level events fire every cycle the level holds, so the status bit
    // stays set through a software clear while the level remains, as the event wins in the clear cycle
    for (genvar i = 0; i < 32; i++)
    begin : g_line
        logic rise;
        logic fall;
        assign rise = line_in[i] && !line_prev_r[i];
        assign fall = !line_in[i] && line_prev_r[i];
        always_comb
        begin
            if (!aim_r[i])
                line_evt[i] = rise || fall;
            else
            begin
                unique case (gpm_pkg::gpm_evt_t'({pol_r[i], el_r[i]}))
                    gpm_pkg::GPM_EVT_FALL: line_evt[i] = fall;
                    gpm_pkg::GPM_EVT_LOW:  line_evt[i] = !line_in[i];
                    gpm_pkg::GPM_EVT_RISE: line_evt[i] = rise;
                    gpm_pkg::GPM_EVT_HIGH: line_evt[i] = line_in[i];
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, mask and output
    // ----------------------------------------------------------------
    always_comb
    begin
        stat_nxt = stat_r;
        if (wr && (addr == `GPM_ADDR_IRQ_STATUS))
            stat_nxt = stat_r & ~wdata;
        stat_nxt = stat_nxt | line_evt;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            stat_r <= `GPM_RST_WORD;
        else
            stat_r <= stat_nxt;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            mask_r <= `GPM_RST_WORD;
        else if (wr && (addr == `GPM_ADDR_IRQ_MASK))
            mask_r <= wdata;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            irq_r <= `GPM_RST_BIT;
        else
            irq_r <= |(stat_r & mask_r);
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = `GPM_RST_WORD;
        if (rd)
        begin
            case (addr)
                `GPM_ADDR_OUT_DATA:    rdata_nxt = output_data_r;
                `GPM_ADDR_IRQ_MASK:    rdata_nxt = mask_r;
                `GPM_ADDR_IRQ_STATUS:  rdata_nxt = stat_r;
                `GPM_ADDR_GATE_STATUS: rdata_nxt = gate_r;
                `GPM_ADDR_AIM_MASK:    rdata_nxt = aim_r;
                `GPM_ADDR_EL_STATUS:   rdata_nxt = el_r;
                `GPM_ADDR_POL_STATUS:  rdata_nxt = pol_r;
                `GPM_ADDR_PROT_MODE:   rdata_nxt = {31'h0, prot_en_r};
                `GPM_ADDR_PROT_STATUS: rdata_nxt = {8'h00, viol_src_r, 7'h00, viol_flag_r};
                default:               rdata_nxt = `GPM_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            rdata_r <= `GPM_RST_WORD;
        else
            rdata_r <= rdata_nxt;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_gate_blocks_data: assert property (
        wr && (addr == `GPM_ADDR_OUT_DATA)
        |=> ((line_out ^ $past(line_out)) & ~$past(gate_r)) == 32'h0)
        else $error("closed gate let a data write through");

    // the bus master leaves one idle cycle between a write and the next read
    chk_gate_status_read: assert property (
        wr && (addr == `GPM_ADDR_GATE_ENABLE) && !prot_en_r
        ##2 rd && (addr == `GPM_ADDR_GATE_STATUS)
        |=> (rdata & $past(wdata, 3)) == $past(wdata, 3))
        else $error("gate status misses enabled lines");

    chk_gate_disable_clrs: assert property (
        wr && (addr == `GPM_ADDR_GATE_DISABLE) && !prot_en_r
        |=> (gate_r & $past(wdata)) == 32'h0)
        else $error("gate disable left lines open");

    chk_aim_enable_sets: assert property (
        wr && (addr == `GPM_ADDR_AIM_ENABLE)
        |=> (aim_r & $past(wdata)) == $past(wdata)
            && (aim_r & ~$past(wdata)) == ($past(aim_r) & ~$past(wdata)))
        else $error("extra mode enable wrong");

    chk_aim_disable_clrs: assert property (
        wr && (addr == `GPM_ADDR_AIM_DISABLE) |=> (aim_r & $past(wdata)) == 32'h0)
        else $error("extra mode disable wrong");

    chk_aim_mask_read: assert property (
        rd && (addr == `GPM_ADDR_AIM_MASK) |=> rdata == $past(aim_r))
        else $error("extra mode mask read wrong");

    chk_edge_level_sel: assert property (
        wr && (addr == `GPM_ADDR_LEVEL_SEL) |=> (el_r & $past(wdata)) == $past(wdata))
        else $error("level select not taken");

    chk_edge_sel_clears: assert property (
        wr && (addr == `GPM_ADDR_EDGE_SEL) |=> (el_r & $past(wdata)) == 32'h0)
        else $error("edge select not taken");

    chk_el_status_read: assert property (
        rd && (addr == `GPM_ADDR_EL_STATUS) |=> rdata == $past(el_r))
        else $error("edge/level status read wrong");

    chk_rise_sel_sets: assert property (
        wr && (addr == `GPM_ADDR_RISE_HIGH_SEL) |=> (pol_r & $past(wdata)) == $past(wdata))
        else $error("rise/high select wrong");

    chk_pol_status_read: assert property (
        rd && (addr == `GPM_ADDR_POL_STATUS) |=> rdata == $past(pol_r))
        else $error("polarity status read wrong");

    chk_polarity_sel: assert property (
        wr && (addr == `GPM_ADDR_FALL_LOW_SEL) |=> (pol_r & $past(wdata)) == 32'h0)
        else $error("fall/low select wrong");

    chk_high_level_evt: assert property (
        aim_r[0] && pol_r[0] && el_r[0] && line_in[0] |=> stat_r[0])
        else $error("high level event lost");

    chk_fall_edge_evt: assert property (
        aim_r[0] && !pol_r[0] && !el_r[0] && !line_in[0] && line_prev_r[0] |=> stat_r[0])
        else $error("falling edge event lost");

    chk_both_edge_evt: assert property (
        !aim_r[0] && (line_in[0] != line_prev_r[0]) |=> stat_r[0])
        else $error("default mode edge lost");

    chk_good_key_write: assert property (
        wr && (addr == `GPM_ADDR_PROT_MODE) && key_ok |=> prot_en_r == $past(wdata[0]))
        else $error("keyed write did not set protection");

    chk_key_gates_enable: assert property (
        wr && (addr == `GPM_ADDR_PROT_MODE) && !key_ok |=> $stable(prot_en_r))
        else $error("wrong key changed protection");

    chk_key_reads_zero: assert property (
        rd && (addr == `GPM_ADDR_PROT_MODE) |=> rdata[31:1] == 31'h0)
        else $error("key field read not zero");

    chk_viol_flag_cycle: assert property (
        violation ##2 (rd && (addr == `GPM_ADDR_PROT_STATUS))
        |=> rdata[0] ##0 !viol_flag_r)
        else $error("violation flag set/clear wrong");

    chk_viol_flag_sets: assert property (
        violation |=> viol_flag_r)
        else $error("violation flag not set");

    chk_viol_src_capture: assert property (
        violation |=> viol_src_r == {8'h00, $past(addr[7:0])})
        else $error("violation source wrong");

    chk_protect_holds: assert property (
        gate_wr && prot_en_r |=> $stable(gate_r))
        else $error("protected gate register changed");

    cov_violation: cover property (violation ##2 rd && (addr == `GPM_ADDR_PROT_STATUS));
    cov_level_refire: cover property (aim_r[0] && el_r[0] && wr
        && (addr == `GPM_ADDR_IRQ_STATUS) ##1 stat_r[0]);
    cov_key_refused: cover property (wr && (addr == `GPM_ADDR_PROT_MODE) && !key_ok);
    cov_irq_rise:  cover property (!irq_r ##1 irq_r);
    cov_gated_wr:  cover property (wr && (addr == `GPM_ADDR_OUT_DATA) && (gate_r != 32'h0));

endmodule

// ===== verification/gpm_testbench.sv
`timescale 1ns/100ps
`include "gpm_defines.svh"

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end

module testbench;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int WATCHDOG_CYCLES = 20000;

    logic               clk;
    logic               reset;
    logic [31:0]        addr;
    logic [31:0]        wdata;
    logic               wr;
    logic               rd;
    gpm_pkg::gpm_word_t rdata;
    logic [31:0]        line_in;
    gpm_pkg::gpm_word_t line_out;
    logic               irq;
    int                 err_count;
    int                 compares;
    logic [31:0]        gate_m;
    logic [31:0]        out_m;
    logic [31:0]        aim_m;
    logic [31:0]        el_m;
    logic [31:0]        pol_m;
    logic [31:0]        d;
    logic [31:0]        v;
    logic [31:0]        cmd_a [6] = '{`GPM_ADDR_AIM_ENABLE, `GPM_ADDR_AIM_DISABLE,
        `GPM_ADDR_EDGE_SEL, `GPM_ADDR_LEVEL_SEL, `GPM_ADDR_FALL_LOW_SEL, `GPM_ADDR_RISE_HIGH_SEL};
    // last entry is unmapped and must read zero as well
    logic [31:0]        ro_a [7] = '{`GPM_ADDR_GATE_STATUS, `GPM_ADDR_AIM_MASK,
        `GPM_ADDR_EL_STATUS, `GPM_ADDR_POL_STATUS, `GPM_ADDR_PROT_MODE,
        `GPM_ADDR_PROT_STATUS, 32'h400e0efc};

    gpm_port_ctrl dut
    (
        .clk      (clk),
        .reset    (reset),
        .addr     (addr),
        .wdata    (wdata),
        .wr       (wr),
        .rd       (rd),
        .rdata    (rdata),
        .line_in  (line_in),
        .line_out (line_out),
        .irq      (irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // bus tasks and expectation helpers
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] x);
        @(posedge clk);
        addr  <= a;
        wdata <= x;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [31:0] a, output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 q = rdata;
    endtask

    function automatic void apply(input int i, input logic [31:0] x);
        case (i)
            0: aim_m = aim_m | x;
            1: aim_m = aim_m & ~x;
            2: el_m  = el_m & ~x;
            3: el_m  = el_m | x;
            4: pol_m = pol_m & ~x;
            default: pol_m = pol_m | x;
        endcase
    endfunction

    task automatic cmd(input int i, input logic [31:0] x);
        apply(i, x);
        wr_reg(cmd_a[i], x);
    endtask

    task automatic check_modes;
        logic [31:0] q;
        rd_reg(`GPM_ADDR_AIM_MASK, q);
        `CHK(q, aim_m)
        rd_reg(`GPM_ADDR_EL_STATUS, q);
        `CHK(q, el_m)
        rd_reg(`GPM_ADDR_POL_STATUS, q);
        `CHK(q, pol_m)
    endtask

    task automatic check_evt(input logic e);
        logic [31:0] q;
        rd_reg(`GPM_ADDR_IRQ_STATUS, q);
        `CHK(q[0], e)
    endtask

    // back is the status expected after returning to the idle level
    task automatic evt_run(input logic lvl, input logic hi, input logic back);
        line_in[0] <= ~hi;
        repeat (3) @(posedge clk);
        wr_reg(`GPM_ADDR_IRQ_STATUS, 32'h1);
        check_evt(1'b0);
        @(posedge clk);
        line_in[0] <= hi;
        repeat (3) @(posedge clk);
        check_evt(1'b1);
        `CHK(irq, 1'b1)
        wr_reg(`GPM_ADDR_IRQ_STATUS, 32'h1);
        check_evt(lvl);
        @(posedge clk);
        line_in[0] <= ~hi;
        repeat (3) @(posedge clk);
        check_evt(back);
        wr_reg(`GPM_ADDR_IRQ_STATUS, 32'h1);
        check_evt(1'b0);
        `CHK(irq, 1'b0)
    endtask

    task automatic close_out;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial
    begin
        #(WATCHDOG_CYCLES * 20);
        err_count++;
        close_out();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        reset = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 32'h0;
        wdata = 32'h0;
        line_in = 32'h0;
        {gate_m, out_m, aim_m, el_m, pol_m} = '0;
        err_count = 0;
        compares = 0;
        void'($urandom(62809));
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        foreach (ro_a[i])
        begin
            rd_reg(ro_a[i], v);
            `CHK(v, 32'h0)
        end
        $display("test reset values done");
        for (int i = 0; i < 10; i++)
        begin
            d = (i == 0) ? 32'hffffffff : $urandom;
            if (i % 2 == 0)
            begin
                wr_reg(`GPM_ADDR_GATE_ENABLE, d);
                gate_m = gate_m | d;
            end
            else
            begin
                wr_reg(`GPM_ADDR_GATE_DISABLE, d);
                gate_m = gate_m & ~d;
            end
            rd_reg(`GPM_ADDR_GATE_STATUS, v);
            `CHK(v, gate_m)
            d = $urandom;
            wr_reg(`GPM_ADDR_OUT_DATA, d);
            out_m = (d & gate_m) | (out_m & ~gate_m);
            #1 `CHK(line_out, out_m)
        end
        $display("test output gate done");
        for (int i = 0; i < 24; i++)
        begin
            d = (i == 0) ? 32'hffffffff : ((i == 1) ? 32'h0 : $urandom);
            cmd($urandom % 6, d);
            check_modes();
        end
        $display("test mode registers done");
        wr_reg(`GPM_ADDR_IRQ_MASK, 32'h1);
        for (int k = 0; k < 4; k++)
        begin
            cmd(0, 32'h1);
            cmd((k % 2 == 1) ? 3 : 2, 32'h1);
            cmd((k >= 2) ? 5 : 4, 32'h1);
            evt_run(k % 2 == 1, k >= 2, k % 2 == 1);
        end
        cmd(1, 32'h1);
        evt_run(1'b0, 1'b1, 1'b1);
        wr_reg(`GPM_ADDR_IRQ_MASK, 32'h0);
        line_in[0] <= 1'b1;
        repeat (3) @(posedge clk);
        check_evt(1'b1);
        `CHK(irq, 1'b0)
        $display("test interrupt events done");
        wr_reg(`GPM_ADDR_PROT_MODE, {24'h123456, 8'h01});
        rd_reg(`GPM_ADDR_PROT_MODE, v);
        `CHK(v, 32'h0)
        wr_reg(`GPM_ADDR_PROT_MODE, {`GPM_KEY_VALUE, 8'h01});
        rd_reg(`GPM_ADDR_PROT_MODE, v);
        `CHK(v, 32'h1)
        wr_reg(`GPM_ADDR_GATE_ENABLE, ~gate_m);
        rd_reg(`GPM_ADDR_PROT_STATUS, v);
        `CHK(v, 32'h0000a001)
        rd_reg(`GPM_ADDR_PROT_STATUS, v);
        `CHK(v, 32'h0000a000)
        wr_reg(`GPM_ADDR_GATE_DISABLE, gate_m);
        rd_reg(`GPM_ADDR_GATE_STATUS, v);
        `CHK(v, gate_m)
        rd_reg(`GPM_ADDR_PROT_STATUS, v);
        `CHK(v, 32'h0000a401)
        wr_reg(`GPM_ADDR_PROT_MODE, {24'h50494e, 8'h00});
        rd_reg(`GPM_ADDR_PROT_MODE, v);
        `CHK(v, 32'h1)
        wr_reg(`GPM_ADDR_PROT_MODE, {`GPM_KEY_VALUE, 8'h00});
        rd_reg(`GPM_ADDR_PROT_MODE, v);
        `CHK(v, 32'h0)
        wr_reg(`GPM_ADDR_GATE_ENABLE, 32'hffffffff);
        rd_reg(`GPM_ADDR_GATE_STATUS, v);
        `CHK(v, 32'hffffffff)
        $display("test write protection done");
        close_out();
    end

endmodule
